// ===== design/fpoc_pkg.sv
// shared constants and types of the flash program operation control
package fpoc_pkg;
  localparam int FPOC_OP_W = 4;
  localparam int FPOC_OP_LSB = 0;
  localparam int FPOC_WORD_W = 32;
  localparam int FPOC_NUM_WORDS = 4;
  localparam int FPOC_ROW_IW = 512;
  localparam int FPOC_PAGE_IW = 4096;
  localparam int FPOC_ROW_BYTES = 2048;
  localparam int FPOC_PAGE_BYTES = 16384;
  localparam int FPOC_PANEL_IW = 262144;
  localparam int FPOC_WORD_CYC = 4;
  localparam int FPOC_ERASE_STEP_CYC = 2;
  localparam logic [3:0] FPOC_OP_RST = 4'h0;
  localparam logic [31:0] FPOC_DATA_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    FPOC_OP_NOP = 4'h0,
    FPOC_OP_WORD = 4'h1,
    FPOC_OP_QUAD = 4'h2,
    FPOC_OP_ROW = 4'h3,
    FPOC_OP_PAGE = 4'h4,
    FPOC_OP_LOWER = 4'h5,
    FPOC_OP_UPPER = 4'h6,
    FPOC_OP_FULL = 4'h7
  } fpoc_op_e;

  typedef struct packed {
    logic start;
    logic erase;
    logic [31:0] count;
  } fpoc_job_s;
endpackage : fpoc_pkg

// ===== design/fpoc_counter.sv
// down counter that paces one operation to completion
`timescale 1ns/100ps
module fpoc_counter #(
  parameter int W = 32
) (
  input wire logic mclk_i, // system clock
  input wire logic srst_i, // sync reset
  input wire logic load_i, // load a new count
  input wire logic [W-1:0] count_i, // cycles to run
  output logic busy_o, // counting
  output logic done_o // pulse in the cycle after the last count
);
  logic [W-1:0] cnt_q;
  wire last = (cnt_q == {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o & last;
      if (load_i) begin
        cnt_q <= count_i;
      end else if (busy_o) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign busy_o = (cnt_q != '0);
endmodule : fpoc_counter

// ===== design/fpoc_ctrl.sv
// operation select, write enable guard and data staging for the flash programmer
`timescale 1ns/100ps
module fpoc_ctrl
  import fpoc_pkg::*;
#(
  parameter int ROW_IW = FPOC_ROW_IW,
  parameter int PAGE_IW = FPOC_PAGE_IW,
  parameter int PANEL_IW = FPOC_PANEL_IW,
  parameter int WORD_CYC = FPOC_WORD_CYC,
  parameter int ERASE_STEP_CYC = FPOC_ERASE_STEP_CYC
) (
  input wire logic mclk_i, // system clock
  input wire logic srst_i, // sync reset
  input wire logic wen_wr_i, // write strobe for write enable bit
  input wire logic flash_write_enable_i, // write enable value
  input wire logic op_wr_i, // write strobe for op field
  input wire logic [3:0] flash_op_code_i, // op field value
  input wire logic data_wr_i, // data word write strobe
  input wire logic [1:0] data_idx_i, // data word index
  input wire logic [31:0] data_i, // data word value
  input wire logic start_i, // start selected operation
  output logic flash_write_enable_o, // write enable state
  output logic [3:0] flash_op_code_o, // selected op
  output logic [127:0] flash_write_data_words_o, // staged quad data
  output logic busy_o, // operation running
  output logic done_o, // completion pulse
  output logic start_rej_o, // start refused pulse
  output logic op_bad_o, // reserved op selected
  output logic pgm_o, // array program strobe held while busy
  output logic ers_o, // array erase strobe held while busy
  output logic [3:0] run_op_o // op being carried out
);
  // job states of the sequencer; code 2'b11 is never entered
  typedef enum logic [1:0] {
    FPOC_ST_IDLE = 2'b00,
    FPOC_ST_PROGRAM = 2'b01,
    FPOC_ST_ERASE = 2'b10
  } fpoc_state_e;

  logic [31:0] data_q [FPOC_NUM_WORDS];
  logic busy_w;
  logic done_w;
  logic load_w;
  logic [31:0] cnt_w;
  logic is_erase_w;
  logic is_valid_w;
  logic is_nop_w;
  logic u_cnt_last_w;
  logic [31:0] left_q;
  logic rej_w;
  logic op_take_w;
  logic data_take_w;
  logic [127:0] words_w;
  fpoc_job_s job_w;
  fpoc_state_e state_q;
  fpoc_state_e state_d;

  // cycle budget per op; reserved codes fall back to zero and never start
  always_comb begin
    cnt_w = 32'h0000_0000;
    is_erase_w = 1'b0;
    is_valid_w = 1'b1;
    unique case (flash_op_code_o)
      FPOC_OP_NOP: cnt_w = 32'h0000_0000;
      FPOC_OP_WORD: cnt_w = 32'(WORD_CYC);
      FPOC_OP_QUAD: cnt_w = 32'(WORD_CYC * FPOC_NUM_WORDS);
      FPOC_OP_ROW: cnt_w = 32'(WORD_CYC * ROW_IW);
      FPOC_OP_PAGE: begin
        cnt_w = 32'(ERASE_STEP_CYC * PAGE_IW);
        is_erase_w = 1'b1;
      end
      FPOC_OP_LOWER, FPOC_OP_UPPER: begin
        cnt_w = 32'(ERASE_STEP_CYC * PANEL_IW);
        is_erase_w = 1'b1;
      end
      FPOC_OP_FULL: begin
        cnt_w = 32'(2 * ERASE_STEP_CYC * PANEL_IW);
        is_erase_w = 1'b1;
      end
      default: is_valid_w = 1'b0;
    endcase
  end

  assign is_nop_w = (flash_op_code_o == FPOC_OP_NOP);
  // nop and reserved codes do nothing; busy rejects
  assign load_w = start_i & ~busy_w & is_valid_w & ~is_nop_w;
  // a start while running is reported, never queued
  assign rej_w = start_i & busy_w;
  assign op_take_w = op_wr_i & flash_write_enable_o & ~busy_w;
  assign data_take_w = data_wr_i & ~busy_w;
  assign words_w = {data_q[3], data_q[2], data_q[1], data_q[0]};
  assign job_w = '{start: load_w, erase: is_erase_w, count: cnt_w};

  fpoc_counter #(
    .W(32)
  ) u_cnt (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .load_i(job_w.start),
    .count_i(job_w.count),
    .busy_o(busy_w),
    .done_o(done_w)
  );

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flash_write_enable_o <= 1'b0;
      flash_op_code_o <= FPOC_OP_RST;
    end else begin
      if (wen_wr_i) begin
        flash_write_enable_o <= flash_write_enable_i;
      end
      // op is frozen while running so the job cannot change under it
      if (op_take_w) begin
        flash_op_code_o <= flash_op_code_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < FPOC_NUM_WORDS; i++) begin
        data_q[i] <= FPOC_DATA_RST;
      end
    end else if (data_take_w) begin
      data_q[data_idx_i] <= data_i;
    end
  end

  // the op field is frozen while busy, so the job kind cannot change mid-job
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FPOC_ST_IDLE: begin
        if (job_w.start) begin
          if (job_w.erase) begin
            state_d = FPOC_ST_ERASE;
          end else begin
            state_d = FPOC_ST_PROGRAM;
          end
        end
      end
      FPOC_ST_PROGRAM, FPOC_ST_ERASE: begin
        if (u_cnt_last_w) begin
          state_d = FPOC_ST_IDLE;
        end
      end
      default: state_d = FPOC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= FPOC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flash_write_data_words_o <= '0;
    end else begin
      flash_write_data_words_o <= words_w;
    end
  end

  // status pulses and flags, registered so the ports come straight from flops
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
      start_rej_o <= 1'b0;
      op_bad_o <= 1'b0;
    end else begin
      done_o <= done_w;
      start_rej_o <= rej_w;
      op_bad_o <= ~is_valid_w;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
      pgm_o <= 1'b0;
      ers_o <= 1'b0;
    end else begin
      busy_o <= (state_d != FPOC_ST_IDLE);
      pgm_o <= (state_d == FPOC_ST_PROGRAM);
      ers_o <= (state_d == FPOC_ST_ERASE);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      run_op_o <= FPOC_OP_RST;
    end else if (job_w.start) begin
      run_op_o <= flash_op_code_o;
    end
  end

  // mirror of the pacing counter, so the last cycle is known one edge early
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      left_q <= 32'h0000_0000;
    end else if (load_w) begin
      left_q <= cnt_w;
    end else if (left_q != 32'h0000_0000) begin
      left_q <= left_q - 32'h0000_0001;
    end
  end
  assign u_cnt_last_w = (left_q == 32'h0000_0001);
endmodule : fpoc_ctrl

// ===== tb/fpoc_properties.sv
// checker for the flash operation control
`timescale 1ns/100ps
module fpoc_properties (
  input wire logic mclk_i, // clk
  input wire logic srst_i, // rst
  input wire logic op_wr_i, // op wr
  input wire logic [3:0] flash_op_code_i, // op in
  input wire logic data_wr_i, // data wr
  input wire logic [1:0] data_idx_i, // index
  input wire logic [31:0] data_i, // data
  input wire logic start_i, // start
  input wire logic flash_write_enable_o, // wen
  input wire logic [3:0] flash_op_code_o, // op
  input wire logic [127:0] flash_write_data_words_o, // words
  input wire logic busy_o, // busy
  input wire logic done_o, // done
  input wire logic start_rej_o, // refused
  input wire logic op_bad_o, // reserved
  input wire logic pgm_o, // program
  input wire logic ers_o, // erase
  input wire logic [3:0] run_op_o // running
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_op_locked: assert property (!$stable(flash_op_code_o) |-> $past(op_wr_i & flash_write_enable_o))
    else $error("op changed unasked");
  a_op_value: assert property (op_wr_i & flash_write_enable_o & !busy_o |=> flash_op_code_o == $past(flash_op_code_i))
    else $error("op not taken");
  a_busy_start: assert property (start_i & !busy_o & flash_op_code_o inside {[1:7]} |=> busy_o)
    else $error("start not taken");
  a_nop_idle: assert property (start_i & !busy_o & (flash_op_code_o == 4'h0 | flash_op_code_o[3]) |=> !busy_o)
    else $error("nop started");
  a_busy_reject: assert property (start_i & busy_o |=> start_rej_o)
    else $error("no refusal");
  a_done_end: assert property ($fell(busy_o) |=> done_o)
    else $error("no done pulse");
  a_bad_code: assert property (op_bad_o == $past(flash_op_code_o[3]))
    else $error("reserved flag wrong");
  a_op_kind: assert property (busy_o |-> pgm_o == (run_op_o inside {[1:3]}) && ers_o == (run_op_o inside {[4:7]}))
    else $error("strobe kind wrong");
  a_data_word: assert property (data_wr_i & !busy_o & data_idx_i == 2'h0 ##1 !(data_wr_i & data_idx_i == 2'h0) |=> flash_write_data_words_o[31:0] == $past(data_i, 2))
    else $error("word 0 wrong");
endmodule : fpoc_properties
bind fpoc_ctrl fpoc_properties i_props (.*);

// ===== tb/testbench.sv
// self-checking bench for the flash operation control
`timescale 1ns/100ps
module testbench;
  import fpoc_pkg::*;
  logic mclk_i = 0, srst_i = 1, wen_wr_i = 0, flash_write_enable_i = 0, op_wr_i = 0, data_wr_i = 0, start_i = 0;
  logic [3:0] flash_op_code_i = 4'h0;
  logic [1:0] data_idx_i = 2'h0;
  logic [31:0] data_i = 32'h0;
  logic flash_write_enable_o, busy_o, done_o, start_rej_o, op_bad_o, pgm_o, ers_o;
  logic [3:0] flash_op_code_o, run_op_o;
  logic [127:0] flash_write_data_words_o;
  int errors = 0, num_checks = 0;
  // cycles per op with the shortened geometry below
  int cnt [1:7] = '{4, 16, 16, 8, 16, 16, 32};
  fpoc_ctrl #(.ROW_IW(4), .PAGE_IW(4), .PANEL_IW(8)) i_dut (.*);
  initial forever #20 mclk_i = ~mclk_i;
  task chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task set_op(input logic en, input logic [3:0] op);
    @(negedge mclk_i);
    {wen_wr_i, flash_write_enable_i} = {1'b1, en};
    @(negedge mclk_i);
    {wen_wr_i, op_wr_i, flash_op_code_i} = {1'b0, 1'b1, op};
    @(negedge mclk_i);
    op_wr_i = 0;
  endtask : set_op
  // start held two edges: second one lands while busy
  task run(input logic [3:0] op, input int n);
    int c;
    int d;
    set_op(1, op);
    start_i = 1;
    repeat (2) @(negedge mclk_i);
    start_i = 0;
    chk(start_rej_o, 1);
    chk({run_op_o, ers_o}, {op, op[2]});
    c = 2;
    d = 0;
    repeat (100) begin
      @(negedge mclk_i);
      c += int'(busy_o);
      d += int'(done_o);
    end
    chk(c, n);
    chk(d, 1);
  endtask : run
  initial begin
    repeat (16) @(negedge mclk_i);
    srst_i = 0;
    chk({flash_write_enable_o, flash_op_code_o, busy_o}, 0);
    set_op(0, 4'h1);
    chk(flash_op_code_o, 0);
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk_i);
      {data_wr_i, data_idx_i, data_i} = {1'b1, 2'(i), {8{4'(i + 1)}}};
    end
    @(negedge mclk_i);
    data_wr_i = 0;
    @(negedge mclk_i);
    chk(flash_write_data_words_o, {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111});
    run(FPOC_OP_QUAD, cnt[2]);
    for (int k = 1; k < 8; k++) run(4'(k), cnt[k]);
    foreach (cnt[k]) begin
      set_op(1, k[0] ? 4'h8 : 4'h0);
      start_i = 1;
      @(negedge mclk_i);
      start_i = 0;
      repeat (3) @(negedge mclk_i);
      chk({op_bad_o, busy_o}, {k[0], 1'b0});
    end
    results();
  end
endmodule : testbench
